// ### logic/nvsram_host_pkg.sv
// package for the nvsram host controller: pin bundles, sequence addresses,
// timing figures and their cycle counts at a 100 MHz clock.
// assumes a single clock domain and no software register map.
package nvsram_host_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned ADDR_W        = 13;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned SEQ_LEN       = 6;

    // access strobe timing, held by the host when it drives the pins
    localparam int unsigned T_CYCLE_NS    = 60;
    localparam int unsigned T_PULSE_NS    = 50;
    localparam int unsigned CYC_CYCLE     =
        (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_PULSE     =
        (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // hardware save: busy must show within 300 ns, inhibit lifts in 700 ns
    localparam int unsigned T_BUSY_NS     = 300;
    localparam int unsigned T_RECOVER_NS  = 700;
    localparam int unsigned T_STORE_MS    = 10;
    localparam int unsigned T_RECALL_US   = 20;
    localparam int unsigned CYC_BUSY      = T_BUSY_NS / CLK_PERIOD_NS;
    localparam int unsigned CYC_RECOVER   =
        (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_STORE     =
        T_STORE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned CYC_RECALL    =
        T_RECALL_US * 1000 / CLK_PERIOD_NS;

    localparam int unsigned CNT_W         = 24;

    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [DATA_W-1:0] data_t;

    // fixed opening addresses, then the two closing ones
    localparam addr_t SEQ_A0       = 13'h0000;
    localparam addr_t SEQ_A1       = 13'h1555;
    localparam addr_t SEQ_A2       = 13'h0aaa;
    localparam addr_t SEQ_A3       = 13'h1fff;
    localparam addr_t SEQ_A4       = 13'h10f0;
    localparam addr_t SEQ_SAVE     = 13'h0f0f;
    localparam addr_t SEQ_RESTORE  = 13'h0f0e;

    function automatic addr_t seq_addr(input logic [2:0] idx,
                                       input logic       restore);
        unique case (idx)
            3'h0:    seq_addr = SEQ_A0;
            3'h1:    seq_addr = SEQ_A1;
            3'h2:    seq_addr = SEQ_A2;
            3'h3:    seq_addr = SEQ_A3;
            3'h4:    seq_addr = SEQ_A4;
            default: seq_addr = restore ? SEQ_RESTORE : SEQ_SAVE;
        endcase
    endfunction

    typedef enum logic [2:0] {
        CMD_READ    = 3'h0,
        CMD_WRITE   = 3'h1,
        CMD_SAVE_SW = 3'h2,
        CMD_RESTORE = 3'h3,
        CMD_SAVE_HW = 3'h4
    } cmd_t;

    typedef struct packed {
        cmd_t  cmd;
        addr_t addr;
        data_t wdata;
    } req_t;

    typedef struct packed {
        logic  chip_sel_n;
        logic  write_n;
        logic  out_drive_n;
        addr_t addr;
        data_t dq_out;
        logic  dq_oe;
        logic  save_oe;
    } pins_t;

endpackage

// ### logic/nvsram_wait_timer.sv
// down-counter used for strobe widths and transfer waits.
// assumes load and a nonzero count arrive together.
`timescale 1ns/1ps
`default_nettype none
module nvsram_wait_timer
    import nvsram_host_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic             load_i,
    input  wire logic [CNT_W-1:0] count_i,
    output logic                  done_o
);
    logic [CNT_W-1:0] remain;

    // counts down to zero; done is high while idle at zero
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            remain <= '0;
        end else if (load_i) begin
            remain <= count_i;
        end else if (remain != '0) begin
            remain <= remain - CNT_W'(1);
        end
    end

    // no load term here: the caller loads on done, which would make a loop
    assign done_o = (remain == '0);
endmodule // nvsram_wait_timer
`default_nettype wire

// ### logic/nvsram_host_ctrl.sv
// host controller for an 8k x 8 nvsram: plain reads and writes, software
// save and restore by six chip-select framed reads, hardware save by
// pulling the save/busy pin low. assumes the pins are wired straight to
// the memory and that inputs are synchronous to clk_i.
// Summary of operation
// [RL1] reads keep write strobe and save/busy pin high throughout.
// [RL2] writes keep save/busy pin high throughout.
// [RL3] write strobe low at select start leaves memory outputs floating.
// [RL4] hardware save copies only if the array was written since.
// [RL5] after hardware save, memory idles until save/busy pin rises.
// [RL6] reads at 0000,1555,0AAA,1FFF,10F0,0F0F in order start a save.
// [RL7] same opening five then 0F0E start a restore; outputs float.
// [RL8] write strobe stays high over all six sequence accesses.
// [RL9] output drive level does not matter for sequence recognition.
// [RL10] inhibit lifts within 700 ns after save/busy pin returns high.
// [RL11] memory shows busy within 300 ns of the pin pulled low.
// [RL12] an access in progress completes before a hardware save begins.
// [RL13] during any copy the memory ignores inputs, outputs disabled.
// [RL14] any foreign access within the six aborts the sequence.
// [RL15] sequence accesses are reads, chip select toggling once each.
// [RL16] chip select and save/busy high mean deselected, outputs float.
`timescale 1ns/1ps
`default_nettype none
module nvsram_host_ctrl
    import nvsram_host_pkg::*;
(
    input  wire logic                     clk_i,
    input  wire logic                     rstn_i,
    input  wire nvsram_host_pkg::req_t    req_i,
    input  wire logic                     req_valid_i,
    output logic                          req_ready_o,
    output nvsram_host_pkg::data_t        rdata_o,
    output logic                          rdata_valid_o,
    output logic                          done_o,
    output nvsram_host_pkg::pins_t        pins_o,
    input  wire nvsram_host_pkg::data_t   dq_i,
    input  wire logic                     save_busy_n_i
);
    import nvsram_host_pkg::*;

    typedef enum logic [6:0] {
        ST_IDLE    = 7'b0000001,
        ST_SETUP   = 7'b0000010,
        ST_STROBE  = 7'b0000100,
        ST_GAP     = 7'b0001000,
        ST_HW_PULL = 7'b0010000,
        ST_HW_WAIT = 7'b0100000,
        ST_XFER    = 7'b1000000
    } state_t;

    state_t           state;
    req_t             cur;
    logic [2:0]       seq_idx;
    logic             busy_seen;
    logic             tmr_load;
    logic [CNT_W-1:0] tmr_count;
    logic             tmr_done;

    wire logic is_seq   = (cur.cmd == CMD_SAVE_SW) ||
                          (cur.cmd == CMD_RESTORE);
    wire logic last_seq = (seq_idx == 3'(SEQ_LEN - 1));

    nvsram_wait_timer u_timer (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .load_i  (tmr_load),
        .count_i (tmr_count),
        .done_o  (tmr_done)
    );

    // timer load points follow state entry
    always_comb begin
        tmr_load  = 1'b0;
        tmr_count = '0;
        unique case (state)
            ST_IDLE: begin
                if (req_valid_i) begin
                    tmr_load  = 1'b1;
                    tmr_count = CNT_W'(1);
                end
            end
            ST_SETUP: begin
                tmr_load  = 1'b1;
                tmr_count = CNT_W'(CYC_PULSE);
            end
            ST_STROBE: begin
                if (tmr_done) begin
                    tmr_load  = 1'b1;
                    // sixth sequence access starts a copy: wait it out
                    if (is_seq && last_seq) begin
                        tmr_count = (cur.cmd == CMD_RESTORE)
                                  ? CNT_W'(CYC_RECALL)
                                  : CNT_W'(CYC_STORE); // RL13
                    end else begin
                        tmr_count = CNT_W'(CYC_CYCLE - CYC_PULSE);
                    end
                end
            end
            ST_HW_PULL: begin
                if (!save_busy_n_i && busy_seen) begin
                    tmr_load  = 1'b1;
                    tmr_count = CNT_W'(CYC_STORE); // RL5
                end
            end
            ST_HW_WAIT: begin
                if (tmr_done) begin
                    tmr_load  = 1'b1;
                    tmr_count = CNT_W'(CYC_RECOVER); // RL10
                end
            end
            default: begin
            end
        endcase
    end

    // main sequencer; a request is only taken in idle so no access
    // is ever cut short by a hardware save
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state   <= ST_IDLE;
            cur     <= '0;
            seq_idx <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (req_valid_i) begin
                        cur     <= req_i;
                        seq_idx <= '0;
                        state   <= (req_i.cmd == CMD_SAVE_HW)
                                 ? ST_HW_PULL : ST_SETUP; // RL12
                    end
                end
                ST_SETUP: state <= ST_STROBE;
                ST_STROBE: begin
                    if (tmr_done) begin
                        state <= (is_seq && last_seq) ? ST_XFER : ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (tmr_done) begin
                        if (is_seq && !last_seq) begin
                            seq_idx <= seq_idx + 3'h1; // RL14
                            state   <= ST_SETUP;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_HW_PULL: begin
                    // memory may drop the copy if nothing was written
                    if (busy_seen) begin
                        state <= ST_HW_WAIT; // RL4
                    end
                end
                ST_HW_WAIT: begin
                    if (tmr_done) begin
                        state <= ST_XFER; // RL5
                    end
                end
                ST_XFER: begin
                    if (tmr_done) begin
                        state <= ST_IDLE; // RL13
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // one-cycle wait after the pull so the pin has a clean sample
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_seen <= 1'b0;
        end else begin
            busy_seen <= (state == ST_HW_PULL) && !busy_seen; // RL11
        end
    end

    // memory pins, all from flops
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pins_o <= '{chip_sel_n: 1'b1, write_n: 1'b1,
                        out_drive_n: 1'b1, addr: '0, dq_out: '0,
                        dq_oe: 1'b0, save_oe: 1'b0}; // RL16
        end else begin
            pins_o.chip_sel_n  <= !(state == ST_SETUP ||
                                    (state == ST_STROBE && !tmr_done));
            // strobe only for plain writes; sequences are reads
            pins_o.write_n     <= !(cur.cmd == CMD_WRITE &&
                                    (state == ST_SETUP ||
                                     (state == ST_STROBE && !tmr_done)));
            // RL1 RL2 RL8 RL15
            pins_o.out_drive_n <= !(state == ST_SETUP ||
                                    (state == ST_STROBE && !tmr_done)) ||
                                  cur.cmd == CMD_WRITE; // RL9
            pins_o.addr        <= is_seq ? seq_addr(seq_idx,
                                  cur.cmd == CMD_RESTORE) // RL6 RL7
                                         : cur.addr;
            pins_o.dq_out      <= cur.wdata;
            pins_o.dq_oe       <= cur.cmd == CMD_WRITE &&
                                  (state == ST_SETUP || state == ST_STROBE);
            // pulled low only through the whole copy; released to recover
            pins_o.save_oe     <= state == ST_HW_PULL ||
                                  (state == ST_HW_WAIT && !tmr_done);
        end
    end

    // read data captured at the end of the strobe; dropped on the
    // sixth sequence access because the memory floats there
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o       <= '0;
            rdata_valid_o <= 1'b0;
        end else begin
            rdata_valid_o <= 1'b0;
            if (state == ST_STROBE && tmr_done &&
                cur.cmd != CMD_WRITE && !(is_seq && last_seq)) begin // RL3
                rdata_o       <= dq_i;
                rdata_valid_o <= 1'b1;
            end
        end
    end

    // handshake outputs
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            req_ready_o <= 1'b0;
            done_o      <= 1'b0;
        end else begin
            req_ready_o <= state == ST_IDLE && !req_valid_i;
            done_o      <= (state == ST_XFER && tmr_done) ||
                           (state == ST_GAP && tmr_done &&
                            !(is_seq && !last_seq));
        end
    end
endmodule // nvsram_host_ctrl
`default_nettype wire

// ### verification/nvsram_host_ctrl_sva.sv
// assertions on the nvsram host controller pins and handshake.
// assumes it is bound onto nvsram_host_ctrl, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module nvsram_host_sva
    import nvsram_host_pkg::*;
(
    input wire logic                   clk_i,
    input wire logic                   rstn_i,
    input wire logic                   req_ready_o,
    input wire logic                   rdata_valid_o,
    input wire nvsram_host_pkg::pins_t pins_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // short views of the pin bundle
    wire logic cs_n = pins_o.chip_sel_n;
    wire logic we_n = pins_o.write_n;
    wire logic sv   = pins_o.save_oe;
    property p_read_pins;
        !cs_n && !pins_o.out_drive_n |-> we_n && !sv && !pins_o.dq_oe;
    endproperty
    a_read_pins: assert property (p_read_pins) else $error("read pins");
    property p_write_pins;
        !cs_n && !we_n |-> !sv && pins_o.dq_oe && pins_o.out_drive_n;
    endproperty
    a_write_pins: assert property (p_write_pins) else $error("wr pins");
    property p_cs_width;
        $fell(cs_n) |-> !cs_n [*6] ##1 cs_n;
    endproperty
    a_cs_width: assert property (p_cs_width) else $error("cs width");
    property p_addr_hold;
        !cs_n ##1 !cs_n |-> $stable(pins_o.addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("addr");
    property p_rvalid_end;
        rdata_valid_o |-> cs_n && we_n;
    endproperty
    a_rvalid_end: assert property (p_rvalid_end) else $error("rvalid");
    property p_save_no_sel;
        sv |-> cs_n && we_n;
    endproperty
    a_save_no_sel: assert property (p_save_no_sel) else $error("sel");
    property p_save_ready;
        sv |-> !req_ready_o;
    endproperty
    a_save_ready: assert property (p_save_ready) else $error("ready");
    // save pin is a held level, not a glitch
    property p_save_hold;
        $rose(sv) |-> sv [*8];
    endproperty
    a_save_hold: assert property (p_save_hold) else $error("save");
endmodule // nvsram_host_sva
bind nvsram_host_ctrl nvsram_host_sva u_sva (.clk_i(clk_i), .rstn_i(rstn_i),
    .req_ready_o(req_ready_o), .rdata_valid_o(rdata_valid_o),
    .pins_o(pins_o));
`default_nettype wire

// ### verification/nvsram_dev_model.sv
// behavioural 8k x 8 nvsram with shadow cells and save/busy pin.
// assumes the bench resolves the data bus and the pulled-up save wire.
`timescale 1ns/1ps
`default_nettype none
module nvsram_dev_model
    import nvsram_host_pkg::*;
#(
    parameter int    STORE_NS  = 5000,
    parameter int    RECALL_NS = 15000,
    parameter data_t NV_INIT   = 8'h5a
)(
    input  wire nvsram_host_pkg::pins_t pins_i,
    input  wire logic                   save_n_i,
    input  wire nvsram_host_pkg::data_t bus_i,
    output logic                        q_oe_o,
    output nvsram_host_pkg::data_t      q_o,
    output logic                        busy_n_o
);
    localparam addr_t OPEN [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
    data_t mem [2**ADDR_W];
    data_t nv  [2**ADDR_W];
    logic  dirty = 1'b0, copying = 1'b0, inhibit = 1'b0;
    logic  sel = 1'b0, wr = 1'b0, w0 = 1'b0;
    addr_t la;
    data_t ld;
    int    idx = 0;
    // pin low from outside also stalls the array
    wire logic blocked = copying || inhibit || !save_n_i;
    wire logic sixth = idx == 5 &&
        (pins_i.addr == SEQ_SAVE || pins_i.addr == SEQ_RESTORE);
    assign q_o = mem[pins_i.addr];
    assign q_oe_o = !pins_i.chip_sel_n && !pins_i.out_drive_n
        && pins_i.write_n && !w0 && !blocked && !sixth;
    initial begin
        busy_n_o = 1'b1;
        foreach (nv[i]) nv[i] = NV_INIT;
        foreach (mem[i]) mem[i] = 8'h00;
    end
    task automatic copy(input logic st);
        copying = 1'b1;
        idx = 0;
        #(st ? STORE_NS : RECALL_NS);
        foreach (mem[i]) if (st) nv[i] = mem[i]; else mem[i] = nv[i];
        dirty = 1'b0;
        copying = 1'b0;
    endtask
    // sequence tracking ignores output drive level
    task automatic finish_access();
        if (blocked) return;
        if (wr) begin
            mem[la] = ld;
            dirty = 1'b1;
            idx = 0;
        end else if (idx == 5 && (la == SEQ_SAVE || la == SEQ_RESTORE))
            fork copy(la == SEQ_SAVE); join_none
        else if (idx < 5 && la == OPEN[idx]) idx++;
        else idx = int'(la == SEQ_A0);
    endtask
    // one access spans one chip select low period
    always @(pins_i, bus_i) begin
        if (!pins_i.chip_sel_n) begin
            if (!sel) begin
                sel = 1'b1;
                wr = 1'b0;
                w0 = !pins_i.write_n;
            end
            la = pins_i.addr;
            if (!pins_i.write_n) begin
                wr = 1'b1;
                ld = bus_i;
            end
        end else if (sel) begin
            sel = 1'b0;
            finish_access();
        end
    end
    task automatic hw_save();
        inhibit = 1'b1;
        wait (pins_i.chip_sel_n);
        if (dirty) begin
            #100 busy_n_o = 1'b0;
            copy(1'b1);
            busy_n_o = 1'b1;
        end
        wait (save_n_i);
        #500 inhibit = 1'b0;
    endtask
    // inhibit guards against our own busy edge retriggering
    always @(negedge save_n_i) begin
        if (!inhibit && !copying) fork hw_save(); join_none
    end
endmodule // nvsram_dev_model
`default_nettype wire

// ### verification/nvsram_host_ctrl_test.sv
// self-checking bench: controller against the nvsram model.
// assumes the package store time stays long, so saves end by reset.
`timescale 1ns/1ps
`default_nettype none
module nvsram_host_ctrl_test;
    import nvsram_host_pkg::*;
    localparam data_t NV = 8'h5a;
    logic  clk_i, rstn_i, req_valid_i, req_ready_o, rdata_valid_o, done_o;
    logic  q_oe, busy_n, save_busy_n_i;
    req_t  req_i;
    pins_t pins_o;
    data_t rdata_o, dq_i, q, flt, rd;
    int    miscompares, samples_checked, nrv;
    // pulled-up save wire; an undriven bus toggles every cycle
    assign save_busy_n_i = busy_n && !pins_o.save_oe;
    assign dq_i = q_oe ? q : pins_o.dq_oe ? pins_o.dq_out : flt;
    nvsram_host_ctrl dut (.clk_i, .rstn_i, .req_i, .req_valid_i,
        .req_ready_o, .rdata_o, .rdata_valid_o, .done_o, .pins_o, .dq_i,
        .save_busy_n_i);
    nvsram_dev_model #(.NV_INIT(NV)) dev (.pins_i(pins_o),
        .save_n_i(save_busy_n_i), .bus_i(dq_i), .q_oe_o(q_oe), .q_o(q),
        .busy_n_o(busy_n));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // floating bus pattern and read data capture
    always @(posedge clk_i) begin
        flt <= ~flt;
        if (rdata_valid_o === 1'b1) begin
            nrv <= nrv + 1;
            rd <= rdata_o;
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic do_reset();
        rstn_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
    endtask
    task automatic issue(input cmd_t c, input addr_t a, input data_t d);
        nrv = 0;
        for (int n = 0; n < 50 && req_ready_o !== 1'b1; n++) @(posedge clk_i);
        req_i <= '{c, a, d};
        req_valid_i <= 1'b1;
        @(posedge clk_i);
        req_valid_i <= 1'b0;
    endtask
    task automatic run(input cmd_t c, input addr_t a, input data_t d,
                       input int lim);
        issue(c, a, d);
        for (int n = 0; n < lim && done_o !== 1'b1; n++) @(posedge clk_i);
        check(done_o, 1'b1);
    endtask
    task automatic t_rw_restore();
        run(CMD_WRITE, 13'h0123, 8'ha5, 40);
        run(CMD_READ, 13'h0123, 8'h00, 40);
        check(rd, 8'ha5);
        check(16'(nrv), 16'h0001);
        check(q_oe, 1'b0);
        run(CMD_WRITE, 13'h0444, 8'h11, 40);
        run(CMD_RESTORE, 13'h0000, 8'h00, 3000);
        check(16'(nrv), 16'h0005);
        run(CMD_READ, 13'h0444, 8'h00, 40);
        check(rd, NV);
        $display("test read write restore finished");
    endtask
    task automatic t_abort_sw_save();
        run(CMD_WRITE, 13'h0444, 8'h22, 40);
        issue(CMD_RESTORE, 13'h0000, 8'h00);
        for (int n = 0; n < 200 && nrv < 3; n++) @(posedge clk_i);
        do_reset();
        run(CMD_READ, SEQ_RESTORE, 8'h00, 40);
        check(rd, NV);
        run(CMD_READ, 13'h0444, 8'h00, 40);
        check(rd, 8'h22);
        run(CMD_WRITE, 13'h0444, 8'h77, 40);
        issue(CMD_SAVE_SW, 13'h0000, 8'h00);
        for (int n = 0; n < 300 && !dev.copying; n++) @(posedge clk_i);
        check(16'(nrv), 16'h0005);
        check(q_oe, 1'b0);
        do_reset();
        for (int n = 0; n < 1000 && dev.copying; n++) @(posedge clk_i);
        check(dev.nv[13'h0444], 8'h77);
        $display("test abort and software save finished");
    endtask
    task automatic t_hw_save();
        int n;
        run(CMD_WRITE, 13'h0555, 8'h99, 40);
        issue(CMD_SAVE_HW, 13'h0000, 8'h00);
        for (n = 0; n < 20 && !pins_o.save_oe; n++) @(posedge clk_i);
        for (n = 0; n < 60 && busy_n; n++) @(posedge clk_i);
        check(n <= CYC_BUSY, 1'b1);
        do_reset();
        for (n = 0; n < 2000 && dev.inhibit; n++) @(posedge clk_i);
        check(dev.nv[13'h0555], 8'h99);
        issue(CMD_SAVE_HW, 13'h0000, 8'h00);
        repeat (40) @(posedge clk_i);
        check(busy_n, 1'b1);
        check(dev.inhibit, 1'b1);
        do_reset();
        repeat (70) @(posedge clk_i);
        check(dev.inhibit, 1'b0);
        run(CMD_READ, 13'h0555, 8'h00, 40);
        check(rd, 8'h99);
        $display("test hardware save finished");
    endtask
    initial begin
        rstn_i = 1'b0;
        req_valid_i = 1'b0;
        req_i = '0;
        flt = 8'h3c;
        miscompares = 0;
        samples_checked = 0;
        nrv = 0;
        do_reset();
        t_rw_restore();
        t_abort_sw_save();
        t_hw_save();
        end_of_test();
    end
    // tests need about 3.5k cycles; allow several times that
    initial begin
        #300000;
        miscompares++;
        end_of_test();
    end
endmodule // nvsram_host_ctrl_test
`default_nettype wire
